// ===== fsp_ctrl.sv
// Flash self-programming controller: holding buffer, unlock key, self-timed program and erase.
// Assumes an Avalon-MM master on the register port, a flash macro with one-cycle read latency,
// rst_n_i as power-on reset and sys_rst_i as a synchronous reset from any other source.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
module fsp_ctrl #(
  parameter logic [31:0] ROW_CYC = 32'(fsp_pkg::ROW_CLK_CYC),
  parameter logic [31:0] ERASE_CYC = 32'(fsp_pkg::ROW_CLK_CYC),
  parameter logic [31:0] WORD_CYC = 32'(fsp_pkg::ROW_CLK_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [23:0] flash_rdata_i,
  output fsp_pkg::fsp_flash_req_s flash_req_o,
  output logic stall_o
);

  fsp_pkg::fsp_state_s st_q;
  fsp_pkg::fsp_state_s st_d;
  logic acc_w;
  logic start_w;
  logic bad_w;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic fsp_pkg::fsp_kind_e decode(input logic erase, input logic [3:0] op);
    decode = fsp_pkg::K_NONE;
    if (erase)
    begin
      unique case (op)
        fsp_pkg::OP_BULK: decode = fsp_pkg::K_BULK;
        fsp_pkg::OP_GSEG: decode = fsp_pkg::K_GSEG;
        fsp_pkg::OP_SSEG: decode = fsp_pkg::K_SSEG;
        fsp_pkg::OP_PAGE: decode = fsp_pkg::K_PAGE;
        fsp_pkg::OP_CFG: decode = fsp_pkg::K_CFGE;
        default: decode = fsp_pkg::K_NONE;
      endcase
    end
    else
    begin
      unique case (op)
        fsp_pkg::OP_WORD: decode = fsp_pkg::K_WORD;
        fsp_pkg::OP_ROW: decode = fsp_pkg::K_ROW;
        fsp_pkg::OP_CFG: decode = fsp_pkg::K_CFGP;
        default: decode = fsp_pkg::K_NONE;
      endcase
    end
  endfunction

  always_comb
  begin
    logic [15:0] cv;
    logic [23:0] word;
    logic [23:0] tgt;
    logic [31:0] dur;
    fsp_pkg::fsp_kind_e k;
    cv = '0;
    word = '0;
    tgt = '0;
    dur = '0;
    k = fsp_pkg::K_NONE;
    st_d = st_q;
    st_d.fl.wr = 1'b0;
    st_d.fl.er = 1'b0;
    st_d.fl.rd = 1'b0;
    st_d.wait_req = 1'b1;
    acc_w = 1'b0;
    start_w = 1'b0;
    bad_w = 1'b0;

    unique case (st_q.fsm)
      fsp_pkg::FSM_IDLE:
      begin
      end
      fsp_pkg::FSM_STREAM:
      begin
        // Stream the whole row buffer to the array
        st_d.fl.wr = 1'b1;
        st_d.fl.addr = st_q.base | {17'h0, st_q.idx, 1'b0};
        st_d.fl.data = st_q.hbuf[st_q.idx];
        st_d.idx = st_q.idx + 6'h01;
        st_d.tmr = st_q.tmr - 32'd1;
        if (st_q.idx == 6'h3f)
        begin
          st_d.fsm = fsp_pkg::FSM_HOLD;
        end
      end
      fsp_pkg::FSM_HOLD:
      begin
        if (st_q.tmr == 32'd0)
        begin
          st_d.fsm = fsp_pkg::FSM_IDLE;
          st_d.busy = 1'b0;
          st_d.wr = 1'b0;
          // Normal completion reads as no error
          st_d.err = 1'b0;
        end
        else
        begin
          st_d.tmr = st_q.tmr - 32'd1;
        end
      end
    endcase

    if (st_q.pend)
    begin
      // Second cycle of a table access
      st_d.pend = 1'b0;
      st_d.wait_req = 1'b0;
      word = st_q.hbuf[st_q.ea[6:1]];
      if (st_q.cmd[fsp_pkg::BIT_CMD_READ])
      begin
        if (!st_q.cmd[fsp_pkg::BIT_CMD_HIGH])
        begin
          st_d.rdata = !st_q.cmd[fsp_pkg::BIT_CMD_BYTE] ? flash_rdata_i[15:0] :
                       (st_q.ea[0] ? {8'h00, flash_rdata_i[15:8]} : {8'h00, flash_rdata_i[7:0]});
        end
        else
        begin
          // High byte, phantom byte reads zero
          st_d.rdata = (st_q.cmd[fsp_pkg::BIT_CMD_BYTE] && st_q.ea[0]) ? 16'h0000 :
                       {8'h00, flash_rdata_i[23:16]};
        end
      end
      else
      begin
        if (!st_q.cmd[fsp_pkg::BIT_CMD_HIGH])
        begin
          // Low word into the holding buffer
          if (!st_q.cmd[fsp_pkg::BIT_CMD_BYTE])
          begin
            word[15:0] = st_q.wdata;
          end
          else if (st_q.ea[0])
          begin
            word[15:8] = st_q.wdata[7:0];
          end
          else
          begin
            word[7:0] = st_q.wdata[7:0];
          end
        end
        else if (!(st_q.cmd[fsp_pkg::BIT_CMD_BYTE] && st_q.ea[0]))
        begin
          // High byte into the holding buffer
          word[23:16] = st_q.wdata[7:0];
        end
        // Buffer slot from the word index within the row
        st_d.hbuf[st_q.ea[6:1]] = word;
      end
    end
    // No register access taken while an operation runs
    else if ((avs_read_i || avs_write_i) && st_q.wait_req && !st_q.busy)
    begin
      acc_w = 1'b1;
      st_d.wait_req = 1'b0;
      st_d.rbus = '0;
      if (avs_address_i == fsp_pkg::OFS_KEY)
      begin
        // Any other key access discards the arming
        st_d.key55 = 1'b0;
        st_d.armed = 1'b0;
        if (avs_write_i && avs_byteenable_i[0])
        begin
          st_d.key55 = avs_writedata_i[7:0] == fsp_pkg::KEY_FIRST;
          st_d.armed = st_q.key55 && (avs_writedata_i[7:0] == fsp_pkg::KEY_SECOND);
        end
      end
      if (avs_write_i)
      begin
        unique case (avs_address_i)
          fsp_pkg::OFS_CTRL:
          begin
            cv = merge16({st_q.wr, st_q.write_enable_bit, st_q.err, 6'h00, st_q.erase, 2'h0, st_q.op},
                         avs_writedata_i[15:0], avs_byteenable_i[1:0]);
            st_d.key55 = 1'b0;
            st_d.armed = 1'b0;
            st_d.write_enable_bit = cv[fsp_pkg::BIT_WRITE_ENABLE_BIT];
            st_d.err = cv[fsp_pkg::BIT_ERR];
            st_d.erase = cv[fsp_pkg::BIT_ERASE];
            st_d.op = cv[3:0];
            // Only a one in the write-start bit acts
            if (avs_byteenable_i[1] && avs_writedata_i[fsp_pkg::BIT_WR])
            begin
              k = decode(cv[fsp_pkg::BIT_ERASE], cv[3:0]);
              if (!st_q.armed || !cv[fsp_pkg::BIT_WRITE_ENABLE_BIT])
              begin
                // Improper start attempt sets the flag
                bad_w = 1'b1;
                st_d.err = 1'b1;
              end
              else if (k != fsp_pkg::K_NONE)
              begin
                start_w = 1'b1;
                st_d.wr = 1'b1;
                st_d.busy = 1'b1;
                st_d.kind = k;
                st_d.fl.kind = k;
                // Configuration space flag from the page top bit
                st_d.fl.cfg = st_q.base[23];
                dur = (k == fsp_pkg::K_ROW) ? ROW_CYC :
                      ((k == fsp_pkg::K_WORD) || (k == fsp_pkg::K_CFGP)) ? WORD_CYC : ERASE_CYC;
                st_d.tmr = dur - 32'd1;
                // Row and page alignment from address zero
                tgt = (k == fsp_pkg::K_PAGE) ? (st_q.base & fsp_pkg::PAGE_MASK) : st_q.base;
                if (k == fsp_pkg::K_ROW)
                begin
                  st_d.fsm = fsp_pkg::FSM_STREAM;
                  st_d.idx = 6'h00;
                  st_d.base = st_q.base & fsp_pkg::ROW_MASK;
                end
                else
                begin
                  st_d.fsm = fsp_pkg::FSM_HOLD;
                  st_d.fl.addr = tgt;
                  st_d.fl.data = st_q.hbuf[st_q.base[6:1]];
                  st_d.fl.wr = (k == fsp_pkg::K_WORD) || (k == fsp_pkg::K_CFGP);
                  st_d.fl.er = !((k == fsp_pkg::K_WORD) || (k == fsp_pkg::K_CFGP));
                end
              end
            end
          end
          fsp_pkg::OFS_PAGE:
          begin
            if (avs_byteenable_i[0])
            begin
              st_d.page = avs_writedata_i[7:0];
            end
          end
          fsp_pkg::OFS_EA: st_d.ea = merge16(st_q.ea, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
          fsp_pkg::OFS_WDATA: st_d.wdata = merge16(st_q.wdata, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
          fsp_pkg::OFS_CMD:
          begin
            if (avs_byteenable_i[0])
            begin
              // Hold the answer one more cycle
              st_d.cmd = avs_writedata_i[2:0];
              st_d.pend = 1'b1;
              st_d.wait_req = 1'b1;
              // Page register on top of the address
              if (avs_writedata_i[fsp_pkg::BIT_CMD_READ])
              begin
                st_d.fl.rd = 1'b1;
                st_d.fl.addr = {st_q.page, st_q.ea};
                st_d.fl.cfg = st_q.page[7];
              end
              else
              begin
                st_d.base = {st_q.page, st_q.ea};
              end
            end
          end
          default:
          begin
          end
        endcase
      end
      else
      begin
        unique case (avs_address_i)
          fsp_pkg::OFS_CTRL: st_d.rbus = {16'h0000, st_q.wr, st_q.write_enable_bit, st_q.err, 6'h00, st_q.erase, 2'h0, st_q.op};
          fsp_pkg::OFS_PAGE: st_d.rbus = {24'h000000, st_q.page};
          fsp_pkg::OFS_EA: st_d.rbus = {16'h0000, st_q.ea};
          fsp_pkg::OFS_WDATA: st_d.rbus = {16'h0000, st_q.wdata};
          fsp_pkg::OFS_RDATA: st_d.rbus = {16'h0000, st_q.rdata};
          // Key, command and unmapped offsets read zero
          default: st_d.rbus = '0;
        endcase
      end
    end

    if (sys_rst_i)
    begin
      st_d.key55 = 1'b0;
      st_d.armed = 1'b0;
      st_d.page = '0;
      st_d.ea = '0;
      st_d.wdata = '0;
      st_d.rdata = '0;
      st_d.pend = 1'b0;
      st_d.wait_req = 1'b1;
    end
  end

  // Control bits see only the power-on reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= fsp_pkg::ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign avs_readdata_o = st_q.rbus;
  assign avs_waitrequest_o = st_q.wait_req;
  assign flash_req_o = st_q.fl;
  assign stall_o = st_q.busy;

  // Checking helpers
  logic [31:0] busy_cnt_q;
  logic [23:0] tbl_addr_w;
  logic [15:0] rd_lo_w;
  logic [7:0] rd_hi_w;
  logic tmr_zero_w;
  logic stream_w;
  logic tbl_cmd_w;
  assign tbl_addr_w = {st_q.page, st_q.ea};
  assign rd_lo_w = flash_rdata_i[15:0];
  assign rd_hi_w = flash_rdata_i[23:16];
  assign tmr_zero_w = st_q.tmr == 32'd0;
  assign stream_w = st_q.fsm == fsp_pkg::FSM_STREAM;
  assign tbl_cmd_w = acc_w && avs_write_i && (avs_address_i == fsp_pkg::OFS_CMD) && avs_byteenable_i[0];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_cnt_q <= '0;
    end
    else
    begin
      busy_cnt_q <= stall_o ? busy_cnt_q + 32'd1 : 32'd0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence low_rd_s;
    tbl_cmd_w && !sys_rst_i && (avs_writedata_i[2:0] == 3'b100);
  endsequence
  sequence high_rd_s;
    tbl_cmd_w && !sys_rst_i && (avs_writedata_i[2:0] == 3'b101);
  endsequence

  addr_form_a: assert property (st_q.fl.rd |-> st_q.fl.addr == $past(tbl_addr_w))
    else $error("table read address not page and offset");
  low_read_a: assert property (low_rd_s |=> ##1 st_q.rdata == $past(rd_lo_w))
    else $error("low word read data wrong");
  high_read_a: assert property (high_rd_s |=> ##1 st_q.rdata == {8'h00, $past(rd_hi_w)})
    else $error("high byte read data wrong");
  row_stream_a: assert property ($rose(stream_w) |=> st_q.fl.wr [*8])
    else $error("row stream interrupted");
  row_count_a: assert property ($fell(stream_w) |-> st_q.fl.addr[6:1] == 6'h3f)
    else $error("row stream not 64 words");
  page_align_a: assert property (st_q.fl.er && (st_q.fl.kind == fsp_pkg::K_PAGE) |-> st_q.fl.addr[9:0] == 10'h000)
    else $error("page erase not aligned");
  tbl_two_cyc_a: assert property (tbl_cmd_w && !sys_rst_i |=> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("table access not two cycles");
  stall_wait_a: assert property (stall_o && $past(stall_o) |-> avs_waitrequest_o)
    else $error("bus answered during operation");
  row_time_a: assert property ($fell(stall_o) && (st_q.kind == fsp_pkg::K_ROW) |-> busy_cnt_q == ROW_CYC)
    else $error("row program duration wrong");
  start_set_a: assert property (start_w |=> st_q.wr && stall_o)
    else $error("start did not begin operation");
  done_clear_a: assert property ($fell(stall_o) |-> !st_q.wr && !st_q.err)
    else $error("write-start left set after completion");
  hw_clear_a: assert property ($fell(st_q.wr) |-> $past(tmr_zero_w) && $past(st_q.busy))
    else $error("write-start cleared early");
  key_read_a: assert property (acc_w && avs_read_i && (avs_address_i == fsp_pkg::OFS_KEY) |=> avs_readdata_o == 32'h0)
    else $error("key register read not zero");
  bad_start_a: assert property (bad_w |=> st_q.err && !stall_o)
    else $error("improper start not flagged");
  ctrl_zero_a: assert property (acc_w && avs_read_i |=> avs_readdata_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  key_order_a: assert property ($rose(st_q.armed) |-> $past(st_q.key55))
    else $error("armed without first key");

endmodule // fsp_ctrl

// ===== fsp_pkg.sv
// Package for the flash self-programming controller: offsets, fields, codes, timing, types.
// Assumes a 250 MHz core clock and a word-addressed flash array macro next to the block.
package fsp_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_KEY = 5'h04;
  localparam logic [4:0] OFS_PAGE = 5'h08;
  localparam logic [4:0] OFS_EA = 5'h0c;
  localparam logic [4:0] OFS_WDATA = 5'h10;
  localparam logic [4:0] OFS_CMD = 5'h14;
  localparam logic [4:0] OFS_RDATA = 5'h18;

  // Control register field positions
  localparam int unsigned BIT_WR = 15;
  localparam int unsigned BIT_WRITE_ENABLE_BIT = 14;
  localparam int unsigned BIT_ERR = 13;
  localparam int unsigned BIT_ERASE = 6;

  // Table command register field positions
  localparam int unsigned BIT_CMD_HIGH = 0;
  localparam int unsigned BIT_CMD_BYTE = 1;
  localparam int unsigned BIT_CMD_READ = 2;

  // Unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Operation codes
  localparam logic [3:0] OP_BULK = 4'hf;
  localparam logic [3:0] OP_GSEG = 4'hd;
  localparam logic [3:0] OP_SSEG = 4'hc;
  localparam logic [3:0] OP_WORD = 4'h3;
  localparam logic [3:0] OP_PAGE = 4'h2;
  localparam logic [3:0] OP_ROW = 4'h1;
  localparam logic [3:0] OP_CFG = 4'h0;

  // Array geometry: 64 words a row, 8 rows a page, two addresses per word
  localparam int unsigned ROW_WORDS = 64;
  localparam logic [23:0] ROW_MASK = 24'hffff80;
  localparam logic [23:0] PAGE_MASK = 24'hfffc00;

  // Timing: fast RC oscillator cycle counts scaled to the core clock, rounded up
  localparam longint unsigned CLK_KHZ = 250000;
  localparam longint unsigned FRC_KHZ = 7370;
  localparam longint unsigned ROW_FRC_CYC = 11064;
  localparam longint unsigned ROW_CLK_CYC = (ROW_FRC_CYC * CLK_KHZ + FRC_KHZ - 1) / FRC_KHZ;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'b001,
    FSM_STREAM = 3'b010,
    FSM_HOLD = 3'b100
  } fsp_fsm_e;

  typedef enum logic [8:0] {
    K_NONE = 9'h001,
    K_BULK = 9'h002,
    K_GSEG = 9'h004,
    K_SSEG = 9'h008,
    K_PAGE = 9'h010,
    K_CFGE = 9'h020,
    K_WORD = 9'h040,
    K_ROW = 9'h080,
    K_CFGP = 9'h100
  } fsp_kind_e;

  typedef struct packed {
    logic wr;
    logic er;
    logic rd;
    logic cfg;
    fsp_kind_e kind;
    logic [23:0] addr;
    logic [23:0] data;
  } fsp_flash_req_s;

  typedef struct packed {
    fsp_fsm_e fsm;
    logic busy;
    logic wr;
    logic write_enable_bit;
    logic err;
    logic erase;
    logic [3:0] op;
    logic key55;
    logic armed;
    logic [7:0] page;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic pend;
    logic [2:0] cmd;
    logic wait_req;
    logic [31:0] rbus;
    logic [23:0] base;
    logic [5:0] idx;
    logic [31:0] tmr;
    fsp_kind_e kind;
    fsp_flash_req_s fl;
    logic [ROW_WORDS-1:0][23:0] hbuf;
  } fsp_state_s;

  localparam fsp_state_s ST_RST = '{fsm: FSM_IDLE, kind: K_NONE, wait_req: 1'b1, fl: '{kind: K_NONE, default: '0},
                                    default: '0};

endpackage

// ===== fsp_flash_model.sv
// Behavioural flash array facing the controller's request port.
// Assumes registered one-cycle request pulses; read data settle within the request cycle.
`timescale 1ns/10ps
module fsp_flash_model (
  input wire clk_i,
  input wire fsp_pkg::fsp_flash_req_s req_i,
  output logic [23:0] rdata_o
);
  logic [23:0] mem [logic [23:0]];
  initial rdata_o = 24'h000000;
  always @(posedge clk_i)
  begin
    if (req_i.wr)
      mem[req_i.addr] = req_i.data;
  end
  // Read answered mid-cycle so the controller captures it at the next edge
  always @(negedge clk_i)
  begin
    // Outside a read of a written address the data lines show the inverse of the last value
    if (req_i.rd && mem.exists(req_i.addr))
      rdata_o <= mem[req_i.addr];
    else
      rdata_o <= ~rdata_o;
  end
endmodule // fsp_flash_model

// ===== fsp_ctrl_test.sv
// Self-checking bench for the flash self-programming controller.
// Assumes the array model above and short operation counts via parameters.
`timescale 1ns/10ps
module fsp_ctrl_test;
  localparam logic [31:0] DUR = 32'h64;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [23:0] frd;
  fsp_pkg::fsp_flash_req_s freq;
  logic stall;
  int n_mismatch = 0;
  int n_checks = 0;
  int scnt = 0;
  int i;
  logic [63:0] rd_q[$];
  logic [63:0] fl_q[$];
  logic [23:0] base = 24'h0;
  logic [15:0] lo;
  logic [7:0] hi;
  logic [3:0] ec[4] = '{4'hf, 4'hd, 4'hc, 4'h2};
  fsp_pkg::fsp_kind_e ek[4] = '{fsp_pkg::K_BULK, fsp_pkg::K_GSEG, fsp_pkg::K_SSEG, fsp_pkg::K_PAGE};
  logic [4:0] nop[8] = '{5'h13, 5'h11, 5'h0f, 5'h0d, 5'h0c, 5'h02, 5'h14, 5'h07};

  always #2 clk_i = ~clk_i;

  fsp_ctrl #(.ROW_CYC(DUR), .ERASE_CYC(DUR), .WORD_CYC(DUR)) fsp_ctrl_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'h3), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .flash_rdata_i(frd), .flash_req_o(freq), .stall_o(stall));
  fsp_flash_model fsp_flash_model_inst (.clk_i(clk_i), .req_i(freq), .rdata_o(frd));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // Avalon master: holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [15:0] e);
    int n;
    @(posedge clk_i);
    if (!w)
      rd_q.push_back({48'h0, e});
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= {16'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 5000);
    if (n >= 5000)
    begin
      n_mismatch++;
      summarize();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Loads one holding-buffer word through low and high table writes
  task automatic tw(input logic [7:0] pg, input logic [15:0] ea, input logic [15:0] l, input logic [7:0] h);
    bus(1, fsp_pkg::OFS_PAGE, {8'h0, pg}, 0);
    bus(1, fsp_pkg::OFS_EA, ea, 0);
    bus(1, fsp_pkg::OFS_WDATA, l, 0);
    bus(1, fsp_pkg::OFS_CMD, 16'h0, 0);
    bus(1, fsp_pkg::OFS_WDATA, {8'h0, h}, 0);
    bus(1, fsp_pkg::OFS_CMD, 16'h1, 0);
    base = {pg, ea};
  endtask

  // Unlock, start, time the stall, then read back the control register
  task automatic run(input logic e, input logic [3:0] c, input fsp_pkg::fsp_kind_e k, input logic [23:0] a,
                     input logic [23:0] d);
    int s;
    int n;
    if (k != fsp_pkg::K_NONE && k != fsp_pkg::K_ROW)
      fl_q.push_back({4'h0, !e, e, base[23], k, a, e ? 24'h0 : d});
    bus(1, fsp_pkg::OFS_KEY, 16'h55, 0);
    bus(1, fsp_pkg::OFS_KEY, 16'haa, 0);
    s = scnt;
    bus(1, fsp_pkg::OFS_CTRL, {2'b11, 7'h0, e, 2'b00, c}, 0);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (stall !== 1'b0 && n < 5000);
    if (n >= 5000)
    begin
      n_mismatch++;
      summarize();
    end
    cmp(k == fsp_pkg::K_NONE ? 0 : DUR, scnt - s);
    bus(0, fsp_pkg::OFS_CTRL, 0, {2'b01, 7'h0, e, 2'b00, c});
  endtask

  // Compares each read answer and each program or erase pulse with the oldest note
  always @(negedge clk_i)
  begin
    if (stall === 1'b1)
      scnt++;
    if (rd && wreq === 1'b0)
      cmp(rd_q.size() ? rd_q.pop_front() : 64'hx, {32'h0, rdat});
    if (freq.wr !== 1'b0 || freq.er !== 1'b0)
      cmp(fl_q.size() ? fl_q.pop_front() : 64'hx,
          {4'h0, freq.wr, freq.er, freq.cfg, freq.kind, freq.addr, freq.er ? 24'h0 : freq.data});
  end

  initial
  begin
    void'($urandom(40));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(0, fsp_pkg::OFS_CTRL, 0, 16'h0);
    bus(0, fsp_pkg::OFS_KEY, 0, 16'h0);
    bus(0, 5'h1c, 0, 16'h0);
    bus(1, fsp_pkg::OFS_CTRL, 16'hc0ff, 0);
    bus(0, fsp_pkg::OFS_CTRL, 0, 16'h604f);
    tw(8'h01, 16'h0004, 16'h1234, 8'h56);
    run(0, 4'h3, fsp_pkg::K_WORD, 24'h010004, 24'h561234);
    bus(1, fsp_pkg::OFS_CMD, 16'h4, 0);
    bus(0, fsp_pkg::OFS_RDATA, 0, 16'h1234);
    bus(1, fsp_pkg::OFS_CMD, 16'h5, 0);
    bus(0, fsp_pkg::OFS_RDATA, 0, 16'h0056);
    for (i = 0; i < 64; i++)
    begin
      lo = 16'($urandom);
      hi = 8'($urandom);
      tw(8'h00, 16'h0180 + 16'(2 * i), lo, hi);
      fl_q.push_back({4'h0, 1'b1, 1'b0, 1'b0, fsp_pkg::K_ROW, 24'h000180 + 24'(2 * i), hi, lo});
    end
    run(0, 4'h1, fsp_pkg::K_ROW, 0, 0);
    tw(8'h02, 16'h0456, 16'h0, 8'h0);
    for (i = 0; i < 4; i++)
      run(1, ec[i], ek[i], i == 3 ? base & fsp_pkg::PAGE_MASK : base, 0);
    tw(8'h80, 16'h0002, 16'hbeef, 8'h3c);
    run(1, 4'h0, fsp_pkg::K_CFGE, 24'h800002, 0);
    run(0, 4'h0, fsp_pkg::K_CFGP, 24'h800002, 24'h3cbeef);
    for (i = 0; i < 8; i++)
      run(nop[i][4], nop[i][3:0], fsp_pkg::K_NONE, 0, 0);
    bus(1, fsp_pkg::OFS_KEY, 16'h55, 0);
    bus(1, fsp_pkg::OFS_KEY, 16'haa, 0);
    bus(1, fsp_pkg::OFS_CTRL, 16'h8003, 0);
    bus(0, fsp_pkg::OFS_CTRL, 0, 16'h2003);
    bus(1, fsp_pkg::OFS_KEY, 16'h55, 0);
    bus(0, fsp_pkg::OFS_KEY, 0, 16'h0);
    bus(1, fsp_pkg::OFS_KEY, 16'haa, 0);
    bus(1, fsp_pkg::OFS_CTRL, 16'hc003, 0);
    bus(0, fsp_pkg::OFS_CTRL, 0, 16'h6003);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(0, fsp_pkg::OFS_CTRL, 0, 16'h6003);
    bus(0, fsp_pkg::OFS_PAGE, 0, 16'h0);
    repeat (4) @(posedge clk_i);
    cmp(0, rd_q.size() + fl_q.size());
    summarize();
  end
endmodule // fsp_ctrl_test
